/* File: hw/hda_defs.svh */
// constants for the hub and its dma arbiter
// assumes one system clock shared with cpu and spoke slaves
`ifndef HDA_DEFS_SVH
`define HDA_DEFS_SVH
`define HDA_NSPOKE     8
`define HDA_SPOKE_LSB  28
`define HDA_SPOKE_SRAM 3'h0
`define HDA_SPOKE_IO   3'h1
`define HDA_SPOKE_CFG  3'h2
`define HDA_NCH        24
`define HDA_DESC_NUM   127
`define HDA_DESC_NONE  7'h7f
`define HDA_FAIR_LVL   3'h2
`define HDA_OWN_CPU    2'h1
`define HDA_OWN_RD     2'h2
`define HDA_OWN_WR     2'h3
`endif

/* File: hw/hda_hub.sv */
// peripheral_hub with two masters, eight spokes and a multi-channel dma engine
// assumes spoke slaves and cpu run on clk_in; trigger pins are asynchronous
// Notes on behaviour
// R1: cpu and dma both start bus transactions
// R2: eight parallel spokes toward the peripherals
// R3: spoke 0 sram, 1 io, 2 hub config
// R4: cpu and dma on different spokes overlap
// R5: dma read and write overlap across spokes
// R6: 8, 16, 24, 32 bit accesses
// R7: descriptors from shared pool of 127
// R8: descriptors rewritable in use and chained
// R9: eight priority levels, lower number wins
// R10: start by pin, cpu, or channel completion
// R11: two interrupts per transfer per channel
// R12: transfers can be stalled or cancelled
// R13: length 1 to 64k bytes or unbounded
// R14: bursts of 1 to 127 bytes
// R15: cpu first, yet dma never starved
// R16: preemption only at transaction boundary
// R17: fairness gives levels 2-7 halving shares
// R18: levels 0 and 1 bypass fairness
// R19: round robin within one level
// R20: rotation disable wins ties in level
// R21: without fairness, strict priority only
// R22: single descriptor moves source to sink
// R23: arbitrate per burst, hold until done
`timescale 1ns/1ps
`include "hda_defs.svh"
module hda_hub import hda_pkg::*; #(
    parameter int NCH = `HDA_NCH
) (
    input  wire logic                            clk_in,
    input  wire logic                            rst_b_in,
    input  wire logic                            cpu_req_in,
    input  wire logic                            cpu_we_in,
    input  wire logic [1:0]                      cpu_size_in,
    input  wire logic [31:0]                     cpu_addr_in,
    input  wire logic [31:0]                     cpu_wdata_in,
    output logic                                 cpu_ack_out,
    output logic [31:0]                          cpu_rdata_out,
    output logic [`HDA_NSPOKE-1:0]               spoke_req_out,
    output logic [`HDA_NSPOKE-1:0]               spoke_we_out,
    output logic [`HDA_NSPOKE-1:0][1:0]          spoke_size_out,
    output logic [`HDA_NSPOKE-1:0][31:0]         spoke_addr_out,
    output logic [`HDA_NSPOKE-1:0][31:0]         spoke_wdata_out,
    input  wire logic [`HDA_NSPOKE-1:0]          spoke_ack_in,
    input  wire logic [`HDA_NSPOKE-1:0][31:0]    spoke_rdata_in,
    input  wire logic                            desc_wr_in,
    input  wire logic [6:0]                      desc_idx_in,
    input  wire hda_desc_t                       desc_data_in,
    input  wire logic [NCH-1:0]                  ch_en_in,
    input  wire logic [NCH-1:0][2:0]             ch_prio_in,
    input  wire logic [NCH-1:0]                  ch_rr_dis_in,
    input  wire logic [NCH-1:0][6:0]             ch_first_in,
    input  wire logic [NCH-1:0]                  ch_chain_en_in,
    input  wire logic [NCH-1:0]                  trig_pin_in,
    input  wire logic [NCH-1:0]                  cpu_trig_in,
    input  wire logic [NCH-1:0]                  ch_stall_in,
    input  wire logic [NCH-1:0]                  ch_cancel_in,
    input  wire logic                            fair_en_in,
    output logic [NCH-1:0]                       ch_busy_out,
    output logic [NCH-1:0]                       irq_desc_out,
    output logic [NCH-1:0]                       irq_chain_out
);
    localparam int CW = $clog2(NCH);

    if (NCH < 2 || NCH > 127) begin : g_chk
        $error("hda_hub: NCH out of range");
    end

    typedef struct packed {
        logic [7:0]       sp_req;
        logic [7:0]       sp_we;
        logic [7:0][1:0]  sp_own;
        logic [7:0][1:0]  sp_size;
        logic [7:0][31:0] sp_addr;
        logic [7:0][31:0] sp_wdata;
        logic [7:0]       owed;
        logic             cpu_busy;
        logic             cpu_ack;
        logic [31:0]      cpu_rdata;
        logic [NCH-1:0]   t1;
        logic [NCH-1:0]   t2;
        logic [NCH-1:0]   t3;
        logic [NCH-1:0]   pend;
        logic [NCH-1:0]   irq_d;
        logic [NCH-1:0]   irq_c;
        logic [NCH-1:0][6:0] cur;
        hda_eng_t         st;
        logic [CW-1:0]    ch;
        logic [CW-1:0]    rr;
        hda_desc_t        d;
        logic [31:0]      src;
        logic [31:0]      dst;
        logic [16:0]      rem;
        logic [7:0]       blen;
        logic [7:0]       rdl;
        logic [7:0]       wrl;
        logic             rd_busy;
        logic             wr_busy;
        logic             buf_v;
        logic [31:0]      buf_d;
        logic [6:0]       fair;
    } hda_state_t;

    hda_state_t s;
    hda_state_t n;
    hda_desc_t  desc_pool [0:`HDA_DESC_NUM-1];
    hda_desc_t  wb_desc;
    logic       wb_en;
    logic       cw;
    logic       rw;
    logic       ww;
    logic [2:0] cs;
    logic [2:0] rs;
    logic [2:0] ws;
    logic       gnt;
    logic [CW-1:0] g;
    logic [2:0] best;
    logic [2:0] sel;
    logic [NCH-1:0] elig;
    logic [7:0][NCH-1:0] lv;

    function automatic logic [2:0] spoke_of(input logic [31:0] a);
        return a[`HDA_SPOKE_LSB +: 3]; // [R3]
    endfunction

    function automatic logic [7:0] beat(input logic [1:0] sz);
        return {6'h00, sz} + 8'h01; // [R6]
    endfunction

    function automatic logic [7:0] dec8(input logic [7:0] v, input logic [7:0] b);
        return (v > b) ? v - b : 8'h00;
    endfunction

    // lowest set bit of the slot counter picks the level owed a turn
    function automatic logic [2:0] fair_slot(input logic [6:0] c);
        logic [2:0] l;
        l = 3'h7;
        for (int k = 5; k >= 0; k--) begin
            if (c[k]) l = 3'(k + 2);
        end
        return l;
    endfunction

    function automatic logic [CW-1:0] pick(input logic [NCH-1:0] m, input int start);
        logic [CW-1:0] r;
        logic          f;
        int            j;
        r = '0;
        f = 1'b0;
        for (int k = 0; k < NCH; k++) begin
            j = (start + k) % NCH;
            if (m[j] && !f) begin
                r = CW'(j);
                f = 1'b1;
            end
        end
        return r;
    endfunction

    always_comb begin
        logic [NCH-1:0] fin;
        logic [NCH-1:0] clr;
        logic [16:0]    left;
        logic [7:0]     bl;
        logic           setv;
        logic           dw;
        logic           xd;
        logic           drop;
        int             pv;
        fin = '0;
        clr = '0;
        left = '0;
        bl = '0;
        setv = 1'b0;
        dw = 1'b0;
        xd = 1'b0;
        drop = 1'b0;
        pv = 0;
        n = s;
        n.cpu_ack = 1'b0;
        n.irq_d = '0;
        n.irq_c = '0;
        n.t1 = trig_pin_in;
        n.t2 = s.t1;
        n.t3 = s.t2;
        wb_en = 1'b0;
        wb_desc = s.d;
        cw = cpu_req_in && !s.cpu_busy && !s.cpu_ack; // [R1]
        cs = spoke_of(cpu_addr_in);
        rw = s.st == HDA_E_RUN && !s.rd_busy && !s.buf_v && s.rdl != 8'h00;
        rs = spoke_of(s.src);
        ww = s.st == HDA_E_RUN && !s.wr_busy && s.buf_v;
        ws = spoke_of(s.dst);
        // each spoke arbitrates alone, so different spokes run in parallel
        for (int k = 0; k < `HDA_NSPOKE; k++) begin // [R2] [R4] [R5]
            dw = (ww && ws == 3'(k)) || (rw && rs == 3'(k));
            if (s.sp_req[k] && spoke_ack_in[k]) begin
                n.sp_req[k] = 1'b0;
                case (s.sp_own[k])
                    `HDA_OWN_CPU: begin
                        n.cpu_ack = 1'b1;
                        n.cpu_rdata = spoke_rdata_in[k];
                        n.cpu_busy = 1'b0;
                    end
                    `HDA_OWN_RD: begin
                        n.buf_d = spoke_rdata_in[k];
                        n.buf_v = 1'b1;
                        n.rd_busy = 1'b0;
                    end
                    default: n.wr_busy = 1'b0;
                endcase
            end else if (!s.sp_req[k]) begin
                // cpu wins, but a dma beat it beat once is owed the next turn
                if (cw && cs == 3'(k) && !(dw && s.owed[k])) begin // [R15]
                    n.sp_req[k] = 1'b1;
                    n.sp_own[k] = `HDA_OWN_CPU;
                    n.sp_we[k] = cpu_we_in;
                    n.sp_size[k] = cpu_size_in; // [R6]
                    n.sp_addr[k] = cpu_addr_in;
                    n.sp_wdata[k] = cpu_wdata_in;
                    n.cpu_busy = 1'b1;
                    n.owed[k] = dw;
                end else if (ww && ws == 3'(k)) begin // [R22]
                    n.sp_req[k] = 1'b1;
                    n.sp_own[k] = `HDA_OWN_WR;
                    n.sp_we[k] = 1'b1;
                    n.sp_size[k] = s.d.size;
                    n.sp_addr[k] = s.dst;
                    n.sp_wdata[k] = s.buf_d;
                    n.wr_busy = 1'b1;
                    n.buf_v = 1'b0;
                    n.dst = s.d.dst_inc ? s.dst + {24'h0, beat(s.d.size)} : s.dst;
                    n.wrl = dec8(s.wrl, beat(s.d.size));
                    n.owed[k] = 1'b0;
                end else if (rw && rs == 3'(k)) begin
                    n.sp_req[k] = 1'b1;
                    n.sp_own[k] = `HDA_OWN_RD;
                    n.sp_we[k] = 1'b0;
                    n.sp_size[k] = s.d.size;
                    n.sp_addr[k] = s.src;
                    n.rd_busy = 1'b1;
                    n.src = s.d.src_inc ? s.src + {24'h0, beat(s.d.size)} : s.src;
                    n.rdl = dec8(s.rdl, beat(s.d.size));
                    n.owed[k] = 1'b0;
                end
            end
        end
        elig = s.pend & ~ch_stall_in & ~ch_cancel_in; // [R12]
        lv = '0;
        for (int i = 0; i < NCH; i++) begin
            if (elig[i]) lv[ch_prio_in[i]][i] = 1'b1;
        end
        best = 3'h7;
        for (int l = 7; l >= 0; l--) begin
            if (|lv[l]) best = 3'(l); // [R9] [R21]
        end
        sel = best;
        if (fair_en_in && best >= `HDA_FAIR_LVL && |lv[fair_slot(s.fair)]) begin // [R17] [R18]
            sel = fair_slot(s.fair);
        end
        if (|(lv[sel] & ch_rr_dis_in)) begin
            g = pick(lv[sel] & ch_rr_dis_in, 0); // [R20]
        end else begin
            g = pick(lv[sel], (int'(s.rr) + 1) % NCH); // [R19]
        end
        gnt = s.st == HDA_E_IDLE && |elig;
        case (s.st)
            HDA_E_IDLE: begin
                // a new winner is chosen only between bursts
                if (gnt) begin // [R16] [R23]
                    n.st = HDA_E_RUN;
                    n.ch = g;
                    n.rr = g;
                    n.fair = s.fair + 7'h01;
                    n.d = desc_pool[s.cur[g]]; // [R7]
                    n.src = n.d.src;
                    n.dst = n.d.dst;
                    n.rem = {1'b0, n.d.len_m1} + 17'h00001; // [R13]
                    bl = (n.d.burst == 7'h00) ? 8'h01 : {1'b0, n.d.burst}; // [R14]
                    n.blen = (!n.d.inf && n.rem < {9'h000, bl}) ? n.rem[7:0] : bl;
                    n.rdl = n.blen;
                    n.wrl = n.blen;
                end
            end
            HDA_E_RUN: begin
                if (s.wrl == 8'h00 && !s.wr_busy && !s.rd_busy && !s.buf_v) n.st = HDA_E_WB; // [R23]
            end
            HDA_E_WB: begin
                // progress goes back to the pool so a preempted channel resumes
                left = s.rem - {9'h000, s.blen};
                xd = !s.d.inf && left == 17'h00000; // [R13]
                drop = ch_cancel_in[s.ch] || (xd && s.d.next == `HDA_DESC_NONE); // [R12]
                wb_en = 1'b1;
                wb_desc.src = s.src;
                wb_desc.dst = s.dst;
                wb_desc.len_m1 = left[15:0] - 16'h0001;
                if (xd && s.d.irq_en && !ch_cancel_in[s.ch]) n.irq_d[s.ch] = 1'b1; // [R11]
                if (xd && !drop) n.cur[s.ch] = s.d.next; // [R8]
                if (drop) begin
                    clr[s.ch] = 1'b1;
                    if (!ch_cancel_in[s.ch]) begin
                        fin[s.ch] = 1'b1;
                        n.irq_c[s.ch] = 1'b1; // [R11]
                    end
                end
                n.st = HDA_E_IDLE;
            end
            default: n.st = HDA_E_IDLE;
        endcase
        for (int i = 0; i < NCH; i++) begin
            pv = (i == 0) ? NCH - 1 : i - 1;
            if (ch_cancel_in[i] && !(s.st != HDA_E_IDLE && int'(s.ch) == i)) clr[i] = 1'b1;
            setv = ch_en_in[i] && ((s.t2[i] && !s.t3[i]) || cpu_trig_in[i] ||
                   (fin[pv] && ch_chain_en_in[pv])); // [R10]
            if (setv && (!s.pend[i] || clr[i])) begin
                setv = ch_first_in[i] != `HDA_DESC_NONE;
                if (setv) n.cur[i] = ch_first_in[i];
            end
            // a trigger in the clearing cycle is kept
            n.pend[i] = setv || (s.pend[i] && !clr[i]);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) s <= '0;
        else s <= n;
    end

    // host writes land after writeback so a rewrite in the writeback cycle wins
    always_ff @(posedge clk_in) begin
        if (wb_en) desc_pool[s.cur[s.ch]] <= wb_desc; // [R8]
        if (desc_wr_in && desc_idx_in != `HDA_DESC_NONE) desc_pool[desc_idx_in] <= desc_data_in; // [R7]
    end

    assign cpu_ack_out = s.cpu_ack;
    assign cpu_rdata_out = s.cpu_rdata;
    assign spoke_req_out = s.sp_req;
    assign spoke_we_out = s.sp_we;
    assign spoke_size_out = s.sp_size;
    assign spoke_addr_out = s.sp_addr;
    assign spoke_wdata_out = s.sp_wdata;
    assign ch_busy_out = s.pend;
    assign irq_desc_out = s.irq_d;
    assign irq_chain_out = s.irq_c;

    property p_cpu_first;
        @(posedge clk_in) disable iff (!rst_b_in)
        (cw && ((ww && ws == cs) || (rw && rs == cs)) && !s.sp_req[cs] && !s.owed[cs])
        |=> (spoke_req_out[$past(cs)] && s.sp_own[$past(cs)] == `HDA_OWN_CPU);
    endproperty
    a_cpu_first: assert property (p_cpu_first) else $error("cpu lost a shared spoke"); // [R15]

    property p_no_starve;
        @(posedge clk_in) disable iff (!rst_b_in)
        (cw && rw && rs == cs && !ww && !s.sp_req[cs] && s.owed[cs]) |=> s.rd_busy && !s.cpu_busy;
    endproperty
    a_no_starve: assert property (p_no_starve) else $error("owed dma beat not served"); // [R15]

    property p_parallel;
        @(posedge clk_in) disable iff (!rst_b_in)
        (cw && rw && !ww && cs != rs && !s.sp_req[cs] && !s.sp_req[rs]) |=> s.cpu_busy && s.rd_busy;
    endproperty
    a_parallel: assert property (p_parallel) else $error("cpu and dma serialised"); // [R4]

    property p_rd_wr;
        @(posedge clk_in) disable iff (!rst_b_in)
        (ww && rw && ws != rs && !s.sp_req[ws] && !s.sp_req[rs] && !(cw && (cs == ws || cs == rs)))
        |=> s.wr_busy && s.rd_busy;
    endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("dma read and write serialised"); // [R5]

    property p_hold;
        @(posedge clk_in) disable iff (!rst_b_in)
        (s.st != HDA_E_IDLE ##1 s.st != HDA_E_IDLE) |-> $stable(s.ch);
    endproperty
    a_hold: assert property (p_hold) else $error("grant changed within burst"); // [R23]

    property p_grant;
        @(posedge clk_in) disable iff (!rst_b_in)
        gnt |-> !ch_stall_in[g] && s.pend[g] ##1 (s.st == HDA_E_RUN && s.ch == $past(g));
    endproperty
    a_grant: assert property (p_grant) else $error("stalled or idle channel granted"); // [R12]

    property p_strict;
        @(posedge clk_in) disable iff (!rst_b_in)
        (gnt && (!fair_en_in || |lv[0] || |lv[1])) |-> ch_prio_in[g] == best;
    endproperty
    a_strict: assert property (p_strict) else $error("lower level beat a higher one"); // [R21]

    property p_rr_dis;
        @(posedge clk_in) disable iff (!rst_b_in)
        (gnt && |(lv[sel] & ch_rr_dis_in)) |-> ch_rr_dis_in[g];
    endproperty
    a_rr_dis: assert property (p_rr_dis) else $error("fixed channel lost a tie"); // [R20]

    property p_chain_end;
        @(posedge clk_in) disable iff (!rst_b_in)
        (s.st == HDA_E_WB && !s.d.inf && s.rem == {9'h000, s.blen} && s.d.next == `HDA_DESC_NONE
         && !ch_cancel_in[s.ch]) |=> irq_chain_out[$past(s.ch)] && s.st == HDA_E_IDLE;
    endproperty
    a_chain_end: assert property (p_chain_end) else $error("finished transfer not flagged"); // [R11]
endmodule

/* File: hw/hda_pkg.sv */
// types for the hub and its dma arbiter
// assumes hda_defs.svh supplies the numeric constants
package hda_pkg;
    typedef enum logic [1:0] {HDA_E_IDLE, HDA_E_RUN, HDA_E_WB} hda_eng_t;
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] len_m1;
        logic [6:0]  burst;
        logic [6:0]  next;
        logic [1:0]  size;
        logic        inf;
        logic        src_inc;
        logic        dst_inc;
        logic        irq_en;
    } hda_desc_t;
endpackage

/* File: verification/hda_hub_test.sv */
// self-checking bench for hda_hub with spoke slave model
// assumes hda_spoke_model answers every spoke; cpu port driven by tasks here
`timescale 1ns/1ps
`include "hda_defs.svh"
module hda_hub_test import hda_pkg::*;;
    localparam int NCH = 8;
    logic                  clk_in = 1'b0;
    logic                  rst_b_in = 1'b0;
    logic                  cpu_req_in = 1'b0;
    logic                  cpu_we_in = 1'b0;
    logic [1:0]            cpu_size_in = 2'h0;
    logic [31:0]           cpu_addr_in = 32'h0;
    logic [31:0]           cpu_wdata_in = 32'h0;
    logic                  cpu_ack_out;
    logic [31:0]           cpu_rdata_out;
    logic [7:0]            spoke_req_out, spoke_we_out, spoke_ack_in, go;
    logic [7:0][1:0]       spoke_size_out;
    logic [7:0][31:0]      spoke_addr_out, spoke_wdata_out, spoke_rdata_in;
    logic                  desc_wr_in = 1'b0;
    logic [6:0]            desc_idx_in = 7'h0;
    hda_desc_t             desc_data_in = '0;
    logic [NCH-1:0]        ch_en_in = '1;
    logic [NCH-1:0][2:0]   ch_prio_in = {3'h0, 3'h0, 3'h0, 3'h1, 3'h5, 3'h0, 3'h0, 3'h0};
    logic [NCH-1:0]        ch_rr_dis_in = '0;
    logic [NCH-1:0][6:0]   ch_first_in = {7'h7f, 7'h6, 7'h0, 7'h5, 7'h4, 7'h2, 7'h1, 7'h0};
    logic [NCH-1:0]        ch_chain_en_in = 8'h02;
    logic [NCH-1:0]        trig_pin_in = '0;
    logic [NCH-1:0]        cpu_trig_in = '0;
    logic [NCH-1:0]        ch_stall_in = '0;
    logic [NCH-1:0]        ch_cancel_in = '0;
    logic                  fair_en_in = 1'b0;
    logic [NCH-1:0]        ch_busy_out, irq_desc_out, irq_chain_out;
    logic [31:0]           seed = 32'h7b97deff;
    logic [31:0]           dseed = 32'h7b97deff;
    logic [31:0]           first_addr = 32'h0;
    logic                  arm = 1'b0;
    int                    miscompares = 0;
    int                    checked = 0;

    hda_hub #(.NCH(NCH)) hda_hub_inst (.clk_in, .rst_b_in, .cpu_req_in, .cpu_we_in, .cpu_size_in,
        .cpu_addr_in, .cpu_wdata_in, .cpu_ack_out, .cpu_rdata_out, .spoke_req_out, .spoke_we_out,
        .spoke_size_out, .spoke_addr_out, .spoke_wdata_out, .spoke_ack_in, .spoke_rdata_in,
        .desc_wr_in, .desc_idx_in, .desc_data_in, .ch_en_in, .ch_prio_in, .ch_rr_dis_in,
        .ch_first_in, .ch_chain_en_in, .trig_pin_in, .cpu_trig_in, .ch_stall_in, .ch_cancel_in,
        .fair_en_in, .ch_busy_out, .irq_desc_out, .irq_chain_out);
    hda_spoke_model hda_spoke_model_inst (.clk_in(clk_in), .go_in(go), .req_in(spoke_req_out),
        .we_in(spoke_we_out), .size_in(spoke_size_out), .addr_in(spoke_addr_out),
        .wdata_in(spoke_wdata_out), .ack_out(spoke_ack_in), .rdata_out(spoke_rdata_in));

    always #5 clk_in = ~clk_in;

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [1:0] sz);
        logic [31:0] m;
        m = 32'hffff_ffff >> (8 * (3 - sz));
        return (old & ~m) | (nw & m);
    endfunction

    // slave speed and fairness mode wander every cycle
    always @(posedge clk_in) begin
        #1;
        seed = lfsr(seed);
        go = seed[7:0];
        fair_en_in = seed[8];
    end
    // records the first dma read address on spoke 0 once armed
    always @(posedge clk_in) begin
        if (arm && spoke_req_out[0] === 1'b1 && spoke_we_out[0] === 1'b0) begin
            first_addr <= spoke_addr_out[0];
            arm <= 1'b0;
        end
    end

    task automatic test_done;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic give_up(input string name);
        miscompares++;
        $display("CHECK FAILED %s expected done seen timeout", name);
        test_done();
    endtask
    task automatic tick;
        @(posedge clk_in);
        #1;
    endtask
    task automatic cpu_xfer(input logic we, input logic [1:0] sz, input logic [31:0] a, input logic [31:0] wd,
                            output logic [31:0] rd);
        int n;
        tick();
        cpu_req_in = 1'b1;
        cpu_we_in = we;
        cpu_size_in = sz;
        cpu_addr_in = a;
        cpu_wdata_in = wd;
        n = 0;
        do begin
            tick();
            n++;
        end while (cpu_ack_out !== 1'b1 && n < 100);
        if (n >= 100) begin
            give_up("cpu ack");
        end
        rd = cpu_rdata_out;
        tick();
        cpu_req_in = 1'b0;
    endtask
    task automatic desc_put(input logic [6:0] i, input logic [31:0] s, input logic [31:0] d,
                            input logic [15:0] lm1, input logic [6:0] b, input logic inf);
        tick();
        desc_wr_in = 1'b1;
        desc_idx_in = i;
        desc_data_in = '{src: s, dst: d, len_m1: lm1, burst: b, next: 7'h7f, size: 2'h3, inf: inf,
                         src_inc: 1'b1, dst_inc: 1'b1, irq_en: 1'b1};
        tick();
        desc_wr_in = 1'b0;
    endtask
    task automatic pulse(input logic [NCH-1:0] m);
        tick();
        cpu_trig_in = m;
        tick();
        cpu_trig_in = '0;
    endtask
    task automatic wait_irq(input int c, output logic chain);
        int n;
        chain = 1'b0;
        n = 0;
        do begin
            tick();
            n++;
            if (irq_chain_out[c] === 1'b1) begin
                chain = 1'b1;
            end
        end while (irq_desc_out[c] !== 1'b1 && n < 600);
        if (n >= 600) begin
            give_up("dma irq");
        end
    endtask

    initial begin
        #600000;
        give_up("run time");
    end

    initial begin
        logic [31:0] rd, w;
        logic        ch;
        logic [31:0] src [33];
        int          n;
        repeat (4) tick();
        check("outputs in reset", 32'h0, {spoke_req_out, ch_busy_out, irq_desc_out, 7'h0, cpu_ack_out});
        rst_b_in = 1'b1;
        for (int s = 0; s < 8; s++) begin
            dseed = lfsr(dseed);
            w = dseed;
            cpu_xfer(1'b1, 2'h3, {1'b0, s[2:0], 28'h200}, w, rd);
            cpu_xfer(1'b0, 2'h3, {1'b0, s[2:0], 28'h200}, 32'h0, rd);
            check("cpu read back", w, rd);
            check("spoke memory", w, hda_spoke_model_inst.mem[s][8'h80]);
        end
        for (int z = 0; z < 4; z++) begin
            cpu_xfer(1'b1, 2'h3, 32'h1000_0204, 32'h1122_3344, rd);
            cpu_xfer(1'b1, z[1:0], 32'h1000_0204, 32'hddcc_bbaa, rd);
            cpu_xfer(1'b0, 2'h3, 32'h1000_0204, 32'h0, rd);
            check("access width", merge(32'h1122_3344, 32'hddcc_bbaa, z[1:0]), rd);
        end
        for (int i = 0; i < 33; i++) begin
            dseed = lfsr(dseed);
            src[i] = dseed;
            hda_spoke_model_inst.mem[0][i] = dseed;
        end
        // one descriptor, burst field above length so the length bounds it
        desc_put(7'h0, 32'h0, 32'h3000_0000, 16'h000f, 7'h7f, 1'b0);
        pulse(8'h01);
        wait_irq(0, ch);
        check("chain end irq", 32'h1, {31'h0, ch});
        for (int i = 0; i < 4; i++) begin
            check("dma copy", src[i], hda_spoke_model_inst.mem[3][i]);
        end
        desc_put(7'h1, 32'h10, 32'h4000_0000, 16'h0003, 7'h04, 1'b0);
        desc_put(7'h2, 32'h4000_0000, 32'h5000_0000, 16'h0003, 7'h04, 1'b0);
        tick();
        trig_pin_in[1] = 1'b1;
        repeat (4) tick();
        trig_pin_in[1] = 1'b0;
        wait_irq(2, ch);
        check("chained copy", src[4], hda_spoke_model_inst.mem[5][0]);
        desc_put(7'h4, 32'h40, 32'h6000_0000, 16'h0003, 7'h04, 1'b0);
        desc_put(7'h5, 32'h80, 32'h7000_0000, 16'h0003, 7'h04, 1'b0);
        arm = 1'b1;
        pulse(8'h18);
        wait_irq(3, ch);
        check("first granted read", 32'h80, first_addr);
        check("low level copy", src[16], hda_spoke_model_inst.mem[6][0]);
        check("high level copy", src[32], hda_spoke_model_inst.mem[7][0]);
        // unbounded transfer keeps spoke 0 busy while the cpu competes for it
        desc_put(7'h6, 32'h0, 32'h6000_0100, 16'h0003, 7'h04, 1'b1);
        pulse(8'h40);
        w = 32'h5a5a_0f0f ^ seed;
        cpu_xfer(1'b1, 2'h3, 32'h0000_0300, w, rd);
        cpu_xfer(1'b0, 2'h3, 32'h0000_0300, 32'h0, rd);
        check("cpu beside dma", w, rd);
        check("unbounded busy", 32'h1, {31'h0, ch_busy_out[6]});
        ch_stall_in[6] = 1'b1;
        repeat (30) tick();
        check("stalled requests", 32'h0, {30'h0, spoke_req_out[6], spoke_req_out[0]});
        ch_cancel_in[6] = 1'b1;
        n = 0;
        ch = 1'b0;
        do begin
            tick();
            n++;
            ch = ch | irq_desc_out[6];
        end while (ch_busy_out[6] !== 1'b0 && n < 200);
        check("cancel ends busy", 32'h0, {31'h0, ch_busy_out[6]});
        check("cancel irq", 32'h0, {31'h0, ch});
        ch_cancel_in[6] = 1'b0;
        ch_stall_in[6] = 1'b0;
        pulse(8'h80);
        repeat (10) tick();
        check("end index ignored", 32'h0, {31'h0, ch_busy_out[7]});
        test_done();
    end
endmodule

/* File: verification/hda_spoke_model.sv */
// spoke slave model: 256-word memory per spoke, answers when the bench allows
// assumes the hub keeps one request per spoke and drops it the edge after ack
`timescale 1ns/1ps
`include "hda_defs.svh"
module hda_spoke_model (
    input  wire logic [0:0]                   clk_in,
    input  wire logic [`HDA_NSPOKE-1:0]       go_in,
    input  wire logic [`HDA_NSPOKE-1:0]       req_in,
    input  wire logic [`HDA_NSPOKE-1:0]       we_in,
    input  wire logic [`HDA_NSPOKE-1:0][1:0]  size_in,
    input  wire logic [`HDA_NSPOKE-1:0][31:0] addr_in,
    input  wire logic [`HDA_NSPOKE-1:0][31:0] wdata_in,
    output logic      [`HDA_NSPOKE-1:0]       ack_out,
    output logic      [`HDA_NSPOKE-1:0][31:0] rdata_out
);
    logic [31:0] mem [`HDA_NSPOKE][256];
    initial begin
        ack_out = '0;
        rdata_out = '0;
    end
    // go_in makes the slave prompt or slow; never acks twice for one request
    always @(posedge clk_in) begin
        for (int s = 0; s < `HDA_NSPOKE; s++) begin
            if (req_in[s] && !ack_out[s] && go_in[s]) begin
                ack_out[s] <= 1'b1;
                rdata_out[s] <= mem[s][addr_in[s][9:2]];
                for (int b = 0; b < 4; b++) begin
                    if (we_in[s] && b <= size_in[s]) begin
                        mem[s][addr_in[s][9:2]][b*8+:8] <= wdata_in[s][b*8+:8];
                    end
                end
            end else begin
                ack_out[s] <= 1'b0;
                // read data outside the ack cycle toggles so stale use shows up
                rdata_out[s] <= ~rdata_out[s];
            end
        end
    end
endmodule
